/* File: bench/can_node_model.sv */
// Far-side bus model: turns commanded bus faults into engine event pulses
`timescale 1ns/100ps
`default_nettype none
module can_node_model
   import can_gsf_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic [4:0] fault,
   output var frame_events_s events
);
   // Registered so a fault reaches the engine one clk_sys cycle later and lasts as many whole cycles as it is commanded
   always_ff @(posedge clk_sys) begin
      events <= frame_events_s'(fault);
   end
endmodule : can_node_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the CAN general status and flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import can_gsf_pkg::*;
   logic clk_sys = 0, sys_rst = 1, tie = 0, irq_en = 0, oth = 0, can_irq;
   logic [7:0] tec = 0, rec = 0, sfr_rdata, m;
   logic [4:0] fault = 0;
   logic [15:0] tmr = 0;
   logic [16:0] lf = 17'h106c1;
   sfr_req_s req = '0;
   engine_state_s eng = '0;
   frame_events_s events;
   int num_errors = 0, total_checks = 0;
   can_node_model i_can_node_model (.clk_sys(clk_sys), .fault(fault),
      .events(events));
   can_general_status_and_flags i_can_general_status_and_flags (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(req), .engine(eng),
      .events(events), .can_timer(tmr), .tx_err_count(tec),
      .rx_err_count(rec), .bus_off_state(tie), .timer_interrupt_enable(irq_en),
      .other_irq(oth), .sfr_rdata(sfr_rdata), .can_irq(can_irq));
   initial forever #5 clk_sys = ~clk_sys;
   function automatic logic [16:0] nxt(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction : nxt
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, e, input string n);
      @(negedge clk_sys) req.addr = a;
      @(negedge clk_sys) chk(n, sfr_rdata, e);
   endtask : rd
   task automatic wr(input logic [7:0] d);
      @(negedge clk_sys) req = '{1'b1, 1'b0, 8'h9b, d};
      @(negedge clk_sys) req.wr = 0;
   endtask : wr
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   initial begin
      #100000 num_errors++;
      final_report();
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      sys_rst = 0;
      rd(8'h9b, 8'h00, "flags");
      rd(8'h51, 8'h00, "unmapped");
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_sys);
         lf = nxt(lf);
         eng = engine_state_s'(lf[3:0]);
         tie = lf[4];
         tec = lf[12:5];
         rec = {lf[16], lf[6:0]};
         m = {1'b0, eng.overload_frame_active, 1'b0, eng.tx_busy, eng.rx_busy,
            eng.enabled, tie, (tec[7] | rec[7]) & ~tie};
         rd(8'haa, m, "status");
      end
      for (int i = 0; i < 5; i++) begin
         m = (i == 0) ? 8'h10 : 8'h01 << (i - 1);
         @(negedge clk_sys) fault = 5'b1 << i;
         @(negedge clk_sys) fault = 0;
         rd(8'h9b, m | 8'h80, "event flag");
         chk("irq", {7'h0, can_irq}, 8'h01);
         wr(8'hbf & ~m);
         rd(8'h9b, 8'h00, "cleared");
      end
      @(negedge clk_sys) tmr = 16'hffff;
      @(negedge clk_sys) tmr = 16'h0000;
      rd(8'h9b, 8'h20, "timer wrap");
      chk("masked irq", {7'h0, can_irq}, 8'h00);
      irq_en = 1;
      rd(8'h9b, 8'ha0, "timer irq");
      chk("timer irq", {7'h0, can_irq}, 8'h01);
      wr(8'h9f);
      rd(8'h9b, 8'h00, "timer clr");
      oth = 1;
      rd(8'h9b, 8'h80, "other irq");
      final_report();
   end
endmodule : tb_top
`default_nettype wire

/* File: design/can_general_status_and_flags.sv */
// CAN general status and general interrupt flag registers
`timescale 1ns/100ps
`default_nettype none
`include "can_gsf_regs.svh"

module can_general_status_and_flags
   import can_gsf_pkg::*;
#(
   parameter int TIMER_W   = 16,
   parameter int ERR_CNT_W = 8
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire sfr_req_s             sfr_req,
   input  wire engine_state_s        engine,
   input  wire frame_events_s        events,
   input  wire logic [TIMER_W-1:0]   can_timer,
   input  wire logic [ERR_CNT_W-1:0] tx_err_count,
   input  wire logic [ERR_CNT_W-1:0] rx_err_count,
   input  wire logic          bus_off_state,
   input  wire logic          timer_interrupt_enable,
   input  wire logic          other_irq,
   output logic [7:0]         sfr_rdata,
   output logic               can_irq
);
   // --------------------------------------------------------------
   // Register declarations
   // --------------------------------------------------------------
   logic [7:0]         status_ff;
   logic [7:0]         flags_ff;
   logic [TIMER_W-1:0] timer_prev_ff;
   logic               can_irq_ff;
   logic [7:0]         sfr_rdata_ff;

   // --------------------------------------------------------------
   // Parameter limits
   // --------------------------------------------------------------
   // Wrap detection compares against fixed end points of the timer
   if (TIMER_W != $bits(`TIMER_MAX)) begin : g_bad_timer_w
      $error("timer width does not match the wrap end points");
   end
   // The passive threshold is one bit wider than the counters
   if (ERR_CNT_W + 1 != $bits(`ERR_PASSIVE_LVL)) begin : g_bad_cnt_w
      $error("error counter width does not match the threshold");
   end

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] addr,
                                    input logic [7:0] reg_addr);
      return addr == reg_addr;
   endfunction : addr_is

   function automatic logic over_limit(input logic [ERR_CNT_W-1:0] cnt);
      return {1'b0, cnt} >= `ERR_PASSIVE_LVL;
   endfunction : over_limit

   wire         wr_flags = sfr_req.wr &&
                           addr_is(sfr_req.addr, `ADDR_GEN_INT_FLAGS);
   wire         timer_wrap = (timer_prev_ff == `TIMER_MAX) &&
                             (can_timer == `TIMER_ZERO);
   // Error passive from counters; bus-off is latched by the engine
   wire         passive = over_limit(tx_err_count) ||
                          over_limit(rx_err_count);
   wire         bus_off_flag = bus_off_state;
   // --------------------------------------------------------------
   // Flag next values: writing zero clears, set beats clear
   // --------------------------------------------------------------
   wire [7:0]   set_vec;
   assign set_vec[`BIT_SUMMARY_IT] = 1'b0;
   assign set_vec[`BIT_RSVD_FLAG]  = 1'b0;
   assign set_vec[`BIT_TIMER_OVR]  = timer_wrap;
   assign set_vec[`BIT_BUF_OVR]    = events.buf_full;
   assign set_vec[`BIT_STUFF_ERR]  = events.stuff_err;
   assign set_vec[`BIT_CRC_ERR]    = events.crc_err;
   assign set_vec[`BIT_FORM_ERR]   = events.form_err;
   assign set_vec[`BIT_ACK_ERR]    = events.ack_err;
   wire [7:0]   keep_vec = wr_flags ? (flags_ff & sfr_req.wdata)
                                    : flags_ff;
   wire [7:0]   sticky = (keep_vec | set_vec) & `STICKY_MASK;
   wire         irq_req = (sticky[`BIT_TIMER_OVR] &
                           timer_interrupt_enable)
                        | (|sticky[`BIT_BUF_OVR:`BIT_ACK_ERR])
                        | other_irq;
   wire [7:0]   nxt_flags = {irq_req, 1'b0,
                             sticky[`BIT_TIMER_OVR:`BIT_ACK_ERR]};
   wire [7:0]   nxt_status = {1'b0, engine.overload_frame_active,
                              1'b0, engine.tx_busy,
                              engine.rx_busy,
                              engine.enabled,
                              bus_off_flag, passive & ~bus_off_flag};
   wire [7:0]   nxt_rdata =
      addr_is(sfr_req.addr, `ADDR_GEN_INT_FLAGS) ? flags_ff :
      addr_is(sfr_req.addr, `ADDR_GEN_STATUS)    ? status_ff : `RDATA_IDLE;
   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         flags_ff      <= `FLAGS_RST;
         status_ff     <= `FLAGS_RST;
         timer_prev_ff <= `TIMER_ZERO;
         can_irq_ff    <= 1'b0;
         sfr_rdata_ff  <= `RDATA_IDLE;
      end else begin
         flags_ff      <= nxt_flags;
         status_ff     <= nxt_status;
         timer_prev_ff <= can_timer;
         can_irq_ff    <= irq_req;
         sfr_rdata_ff  <= nxt_rdata;
      end
   end
   assign sfr_rdata = sfr_rdata_ff;
   assign can_irq   = can_irq_ff;
   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   // Flags: timer overrun and the summary image

   timer_wrap_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      timer_wrap |=> flags_ff[`BIT_TIMER_OVR])
      else $error("timer overrun not set on wrap");

   timer_irq_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      flags_ff[`BIT_TIMER_OVR] && timer_interrupt_enable && !wr_flags
      |=> can_irq)
      else $error("timer overrun did not raise interrupt");

   summary_ro_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      flags_ff[`BIT_SUMMARY_IT] == can_irq)
      else $error("summary flag differs from interrupt");

   // A write of one to the summary bit must not be able to set it
   summary_src_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      flags_ff[`BIT_SUMMARY_IT]
      |-> $past(other_irq) ||
          (|flags_ff[`BIT_BUF_OVR:`BIT_ACK_ERR]) ||
          (flags_ff[`BIT_TIMER_OVR] && $past(timer_interrupt_enable)))
      else $error("summary flag set without a source");

   summary_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      other_irq |=> flags_ff[`BIT_SUMMARY_IT] && can_irq)
      else $error("summary flag misses a request");

   // Flags: receive buffer and frame errors

   buf_sticky_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      flags_ff[`BIT_BUF_OVR] && !wr_flags |=> flags_ff[`BIT_BUF_OVR])
      else $error("buffer overrun flag lost");

   buf_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.buf_full |=> flags_ff[`BIT_BUF_OVR] && can_irq)
      else $error("buffer overrun not flagged");

   // Hardware set and software clear in one cycle: the set wins
   set_wins_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.buf_full && wr_flags && !sfr_req.wdata[`BIT_BUF_OVR]
      |=> flags_ff[`BIT_BUF_OVR])
      else $error("clear beat a buffer overrun");

   form_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.form_err |=> flags_ff[`BIT_FORM_ERR] && can_irq)
      else $error("form error not flagged");

   err_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.stuff_err || events.crc_err || events.ack_err
      |=> |flags_ff[`BIT_STUFF_ERR:`BIT_ACK_ERR])
      else $error("frame error not flagged");

   stuff_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.stuff_err |=> flags_ff[`BIT_STUFF_ERR])
      else $error("stuff error not flagged");

   crc_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.crc_err |=> flags_ff[`BIT_CRC_ERR])
      else $error("crc error not flagged");

   ack_set_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      events.ack_err |=> flags_ff[`BIT_ACK_ERR])
      else $error("ack error not flagged");

   // Status: engine levels and fault confinement

   tx_busy_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      engine.tx_busy |=> status_ff[`BIT_TX_BUSY])
      else $error("transmit busy not shown");

   rx_busy_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      engine.rx_busy |=> status_ff[`BIT_RX_BUSY])
      else $error("receive busy not shown");

   enabled_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      engine.enabled |=> status_ff[`BIT_ENABLED])
      else $error("enabled state not shown");

   ovl_flag_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      engine.overload_frame_active |=> status_ff[`BIT_OVERLOAD])
      else $error("overload flag not shown");

   confine_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      bus_off_state |=> status_ff[`BIT_BUS_OFF]
                        && !status_ff[`BIT_ERR_PASSIVE])
      else $error("bus off state wrong");

   passive_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !bus_off_state && over_limit(tx_err_count)
      |=> status_ff[`BIT_ERR_PASSIVE])
      else $error("error passive state not shown");

   // Reserved positions read zero so software sees a stable value
   rsvd_zero_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !status_ff[`BIT_RSVD_HI] && !status_ff[`BIT_RSVD_MID] &&
      !flags_ff[`BIT_RSVD_FLAG])
      else $error("reserved bit reads one");

   unmapped_rd_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !addr_is(sfr_req.addr, `ADDR_GEN_INT_FLAGS) &&
      !addr_is(sfr_req.addr, `ADDR_GEN_STATUS)
      |=> sfr_rdata == `RDATA_IDLE)
      else $error("unmapped read not idle");
endmodule : can_general_status_and_flags
`default_nettype wire

/* File: include/can_gsf_pkg.sv */
// Types shared by the CAN general status and flag block
package can_gsf_pkg;
   typedef struct packed {
      logic overload_frame_active;
      logic tx_busy;
      logic rx_busy;
      logic enabled;
   } engine_state_s;
   typedef struct packed {
      logic stuff_err;
      logic crc_err;
      logic form_err;
      logic ack_err;
      logic buf_full;
   } frame_events_s;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;
endpackage : can_gsf_pkg

/* File: include/can_gsf_regs.svh */
// Register addresses, bit positions and reset values of the CAN status block
`ifndef CAN_GSF_REGS_SVH
`define CAN_GSF_REGS_SVH
`define ADDR_GEN_INT_FLAGS  8'h9b
`define ADDR_GEN_STATUS     8'haa
`define BIT_SUMMARY_IT      7
`define BIT_TIMER_OVR       5
`define BIT_BUF_OVR         4
`define BIT_STUFF_ERR       3
`define BIT_CRC_ERR         2
`define BIT_FORM_ERR        1
`define BIT_ACK_ERR         0
`define BIT_OVERLOAD        6
`define BIT_TX_BUSY         4
`define BIT_RX_BUSY         3
`define BIT_ENABLED         2
`define BIT_BUS_OFF         1
`define BIT_ERR_PASSIVE     0
`define BIT_RSVD_FLAG       6
`define BIT_RSVD_HI         7
`define BIT_RSVD_MID        5
`define STICKY_MASK         8'h3f
`define RDATA_IDLE          8'h00
`define FLAGS_RST           8'h00
`define TIMER_MAX           16'hffff
`define TIMER_ZERO          16'h0000
`define ERR_PASSIVE_LVL     9'h080
`define BUS_OFF_LVL         9'h100
`endif
